//--- core/qtbsr_top.sv
// Query table and block status readout on the multiplexed address/data bus
module qtbsr_top (
  input  wire logic                          clock_in,
  input  wire logic                          nrst_in,
  input  wire logic                          ce_n_in,
  input  wire logic                          adv_n_in,
  input  wire logic                          we_n_in,
  input  wire logic                          oe_n_in,
  input  wire logic [qtbsr_pkg::HI_W-1:0]    addr_hi_in,
  input  wire logic [qtbsr_pkg::DQ_W-1:0]    a_dq_in,
  output logic      [qtbsr_pkg::DQ_W-1:0]    a_dq_out,
  output logic                               a_dq_oe_out,
  input  wire logic [qtbsr_pkg::DQ_W-1:0]    array_data_in,
  input  wire logic [7:0]                    status_byte_in,
  input  wire logic                          op_start_in,
  input  wire logic                          op_erase_in,
  input  wire logic [qtbsr_pkg::BLK_W-1:0]   op_block_in,
  input  wire logic                          erase_done_in,
  input  wire logic                          erase_ok_in,
  input  wire logic [qtbsr_pkg::BLK_W-1:0]   erase_block_in
);
  import qtbsr_pkg::*;

  qtbsr_mem_if mif ();

  logic [ADDR_W-1:0]    addr;
  qtbsr_mode_type       mode [NPART];
  logic                 lock_pending;
  logic                 wr_take;
  logic                 rd_active;
  logic [PART_W-1:0]    cur_part;
  logic [BLK_W-1:0]     cur_blk;
  logic [BLK_LSB-1:0]   cur_blk_off;
  logic [PART_LSB-1:0]  cur_part_off;
  logic [DQ_W-1:0]      next_dq;
  qtbsr_mode_type       out_kind;
  logic [QOFF_W-1:0]    out_off;
  logic                 out_qhit;
  logic                 out_stat;

  // Bus strobes
  assign wr_take   = !ce_n_in && !we_n_in;
  assign rd_active = !ce_n_in && !oe_n_in && we_n_in;

  // Address fields: partition, block base and word offsets
  assign cur_part     = addr[ADDR_W-1:PART_LSB];
  assign cur_blk      = addr[ADDR_W-1:BLK_LSB];
  assign cur_blk_off  = addr[BLK_LSB-1:0];
  assign cur_part_off = addr[PART_LSB-1:0];

  // Word address latch on the address valid strobe
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      addr <= '0;
    end else if (!ce_n_in && !adv_n_in) begin
      addr <= {addr_hi_in, a_dq_in};
    end
  end

  // Read mode of each partition
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < NPART; i++) begin
        mode[i] <= mode_array;
      end
    end else if (wr_take && !lock_pending) begin
      case (a_dq_in)
        CMD_READ_ARRAY:  mode[cur_part] <= mode_array;
        CMD_READ_STATUS: mode[cur_part] <= mode_status;
        CMD_READ_INFO:   mode[cur_part] <= mode_info;
        CMD_QUERY:       mode[cur_part] <= mode_query;
        default:         ;
      endcase
    end
  end

  // Two-cycle lock command sequence
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      lock_pending <= 1'b0;
    end else if (wr_take) begin
      lock_pending <= !lock_pending && (a_dq_in == CMD_LOCK_SETUP);
    end
  end

  // Lock bit updates; lock-down blocks an unlock
  always_comb begin
    mif.cmd_we   = 1'b0;
    mif.cmd_mask = M_NONE;
    mif.cmd_data = M_NONE;
    if (wr_take && lock_pending) begin
      case (a_dq_in)
        CMD_LOCK: begin
          mif.cmd_we   = 1'b1;
          mif.cmd_mask = M_LOCK;
          mif.cmd_data = M_LOCK;
        end
        CMD_LOCKDOWN: begin
          mif.cmd_we   = 1'b1;
          mif.cmd_mask = M_BOTH;
          mif.cmd_data = M_BOTH;
        end
        CMD_UNLOCK: begin
          mif.cmd_we   = !mif.rdata[ENT_LDOWN];
          mif.cmd_mask = M_LOCK;
          mif.cmd_data = M_NONE;
        end
        default: ;
      endcase
    end
  end
  assign mif.cmd_addr = cur_blk;
  assign mif.raddr    = cur_blk;

  // Erase outcome: a new erase operation marks the block; any other new operation, or a good erase with no new operation in the same cycle, clears it
  assign mif.op_we   = op_start_in || erase_done_in;
  assign mif.op_addr = op_start_in ? op_block_in : erase_block_in;
  assign mif.op_data = op_start_in ? op_erase_in : !erase_ok_in;

  qtbsr_mem u_mem (
    .clock_in (clock_in),
    .nrst_in  (nrst_in),
    .mif      (mif)
  );

  // Read data selection by partition mode
  always_comb begin
    next_dq = '0;
    case (mode[cur_part])
      mode_array:  next_dq = array_data_in;
      mode_status: next_dq = {ZERO_BYTE, status_byte_in};
      mode_info: begin
        if (cur_blk_off == STAT_OFF) begin
          next_dq = {ZERO_BYTE, qtbsr_stat_byte(mif.rdata)};
        end
      end
      mode_query: begin
        if (cur_part_off[PART_LSB-1:QOFF_W] == '0) begin
          next_dq = {ZERO_BYTE, qtbsr_query_byte(cur_part_off[QOFF_W-1:0])};
        end
      end
      default: next_dq = '0;
    endcase
  end

  // Registered bus output
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      a_dq_out    <= '0;
      a_dq_oe_out <= 1'b0;
    end else begin
      a_dq_out    <= rd_active ? next_dq : '0;
      a_dq_oe_out <= rd_active;
    end
  end

  // Context of the last read, for checking
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      out_kind <= mode_array;
      out_off  <= '0;
      out_qhit <= 1'b0;
      out_stat <= 1'b0;
    end else begin
      out_kind <= mode[cur_part];
      out_off  <= cur_part_off[QOFF_W-1:0];
      out_qhit <= cur_part_off[PART_LSB-1:QOFF_W] == '0;
      out_stat <= cur_blk_off == STAT_OFF;
    end
  end

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!nrst_in);

  sequence s_query_cmd;
    wr_take && !lock_pending && a_dq_in == CMD_QUERY;
  endsequence

  sequence s_query_read;
    a_dq_oe_out && out_kind == mode_query;
  endsequence

  sequence s_stat_read;
    rd_active && mode[cur_part] == mode_info && cur_blk_off == STAT_OFF;
  endsequence

  a_query_enter: assert property (s_query_cmd |=> mode[$past(cur_part)] == mode_query)
    else $error("query command did not enter query mode");

  a_query_low_byte: assert property (s_query_read |-> a_dq_out[15:8] == ZERO_BYTE
      && a_dq_out[7:0] == (out_qhit ? qtbsr_query_byte(out_off) : ZERO_BYTE))
    else $error("query word not on low byte with zero high byte");

  a_query_string: assert property ((s_query_read and (out_qhit && out_off == Q_OFF_Y))
      |-> a_dq_out == {ZERO_BYTE, QRY_Y} && $past(rd_active))
    else $error("identification string byte wrong");

  a_query_cmdset: assert property ((s_query_read and (out_qhit && out_off == Q_OFF_PID + 8'h1))
      |-> a_dq_out[7:0] == PRIMARY_CMDSET_IDENTIFIER[15:8])
    else $error("command set identifier high byte wrong");

  a_query_alt_zero: assert property ((s_query_read and (out_qhit && out_off == Q_OFF_AID))
      |-> a_dq_out == '0)
    else $error("alternate command set identifier not zero");

  a_stat_path: assert property (s_stat_read ##1 a_dq_oe_out
      |-> a_dq_out[STAT_LOCK] == $past(mif.rdata[ENT_LOCK])
          && a_dq_out[STAT_LDOWN] == $past(mif.rdata[ENT_LDOWN]))
    else $error("block status lock bits not from stored entry");

  a_stat_reserved: assert property (a_dq_oe_out && out_kind == mode_info
      |-> a_dq_out[15:5] == '0 && a_dq_out[3:2] == '0 && (out_stat || a_dq_out == '0))
    else $error("reserved block status bits not zero");

  a_unlock_blocked: assert property (wr_take && lock_pending && a_dq_in == CMD_UNLOCK && mif.rdata[ENT_LDOWN]
      |-> !mif.cmd_we ##1 !lock_pending)
    else $error("unlock acted on a locked-down block");

  a_idle_quiet: assert property (!rd_active |=> !a_dq_oe_out && a_dq_out == '0)
    else $error("bus driven outside a read");

endmodule : qtbsr_top

//--- include/qtbsr_pkg.sv
// Constants, types and helpers for the query table and block status readout
// Summary of operation
// - Writing command 0098h to a partition puts it in query mode, and its reads then return query data.
// - In query mode each query byte is driven on the low eight lines of the address/data bus only.
// - In query mode the upper data byte of every read is zero.
// - Query offsets are word addresses, so each offset selects one 16-bit word.
// - The query database starts at word address 10h of the addressed partition.
// - Words 10h, 11h and 12h return 51h, 52h and 59h in the low byte with a zero upper byte.
// - Multi-byte query fields place the least significant byte at the lowest word address.
// - Words 13h and 14h hold the primary command set identifier, low byte first.
// - Words 15h and 16h hold the word address of the primary extended query table, low byte first.
// - Words 17h and 18h hold a zero alternate command set identifier.
// - The block status byte is read at word offset 02h from each block's base word address.
// - Blocks are 256-kilobyte blocks on word bases, block 1 starting at word 020000h, used by the host for status reads.
// - Bit 0 of the block status byte is 1 for a locked block and 0 for an unlocked one.
// - Bit 1 of the block status byte is 1 for a locked-down block and 0 otherwise.
// - The block status byte carries a last-erase outcome that survives power loss and clears on a new non-erase operation or a good erase if no start coincides.
// - Bits 2, 3, 5, 6 and 7 of the block status byte are reserved.
package qtbsr_pkg;

  // Address geometry, 23-bit word address
  localparam int ADDR_W   = 23;
  localparam int HI_W     = 7;
  localparam int DQ_W     = 16;
  localparam int PART_LSB = 20;
  localparam int PART_W   = 3;
  localparam int NPART    = 8;
  localparam int BLK_LSB  = 17;
  localparam int BLK_W    = 6;
  localparam int NBLK     = 64;
  localparam int QOFF_W   = 8;

  // Commands
  localparam logic [15:0] CMD_READ_ARRAY  = 16'h00ff;
  localparam logic [15:0] CMD_READ_STATUS = 16'h0070;
  localparam logic [15:0] CMD_READ_INFO   = 16'h0090;
  localparam logic [15:0] CMD_QUERY       = 16'h0098;
  localparam logic [15:0] CMD_LOCK_SETUP  = 16'h0060;
  localparam logic [15:0] CMD_LOCK        = 16'h0001;
  localparam logic [15:0] CMD_UNLOCK      = 16'h00d0;
  localparam logic [15:0] CMD_LOCKDOWN    = 16'h002f;

  // Block status layout and stored entry layout
  localparam logic [16:0] STAT_OFF    = 17'h00002;
  localparam int          STAT_LOCK   = 0;
  localparam int          STAT_LDOWN  = 1;
  localparam int          STAT_ERASE  = 4;
  localparam int          ENT_W       = 3;
  localparam int          ENT_LOCK    = 0;
  localparam int          ENT_LDOWN   = 1;
  localparam int          ENT_ERASE   = 2;
  localparam logic [1:0]  M_LOCK      = 2'h1;
  localparam logic [1:0]  M_BOTH      = 2'h3;
  localparam logic [1:0]  M_NONE      = 2'h0;
  localparam logic [7:0]  ZERO_BYTE   = 8'h00;

  // Query table
  localparam logic [7:0]  Q_OFF_Q    = 8'h10;
  localparam logic [7:0]  Q_OFF_R    = 8'h11;
  localparam logic [7:0]  Q_OFF_Y    = 8'h12;
  localparam logic [7:0]  Q_OFF_PID  = 8'h13;
  localparam logic [7:0]  Q_OFF_PTBL = 8'h15;
  localparam logic [7:0]  Q_OFF_AID  = 8'h17;
  localparam logic [7:0]  QRY_Q      = 8'h51;
  localparam logic [7:0]  QRY_R      = 8'h52;
  localparam logic [7:0]  QRY_Y      = 8'h59;
  localparam logic [15:0] PRIMARY_CMDSET_IDENTIFIER   = 16'h0002;
  localparam logic [15:0] PRIMARY_EXT_TABLE_ADDR      = 16'h010a;
  localparam logic [15:0] ALTERNATE_CMDSET_IDENTIFIER = 16'h0000;

  typedef enum logic [1:0] {mode_array, mode_status, mode_info, mode_query} qtbsr_mode_type;

  // Query byte at a word offset, zero where undefined
  function automatic logic [7:0] qtbsr_query_byte(input logic [QOFF_W-1:0] off);
    logic [7:0] b;
    b = ZERO_BYTE;
    case (off)
      Q_OFF_Q:          b = QRY_Q;
      Q_OFF_R:          b = QRY_R;
      Q_OFF_Y:          b = QRY_Y;
      Q_OFF_PID:        b = PRIMARY_CMDSET_IDENTIFIER[7:0];
      Q_OFF_PID + 8'h1: b = PRIMARY_CMDSET_IDENTIFIER[15:8];
      Q_OFF_PTBL:       b = PRIMARY_EXT_TABLE_ADDR[7:0];
      Q_OFF_PTBL + 8'h1: b = PRIMARY_EXT_TABLE_ADDR[15:8];
      Q_OFF_AID:        b = ALTERNATE_CMDSET_IDENTIFIER[7:0];
      Q_OFF_AID + 8'h1: b = ALTERNATE_CMDSET_IDENTIFIER[15:8];
      default:          b = ZERO_BYTE;
    endcase
    return b;
  endfunction : qtbsr_query_byte

  // Block status byte from a stored entry, reserved bits zero
  function automatic logic [7:0] qtbsr_stat_byte(input logic [ENT_W-1:0] e);
    logic [7:0] b;
    b = ZERO_BYTE;
    b[STAT_LOCK]  = e[ENT_LOCK];
    b[STAT_LDOWN] = e[ENT_LDOWN];
    b[STAT_ERASE] = e[ENT_ERASE];
    return b;
  endfunction : qtbsr_stat_byte

endpackage : qtbsr_pkg

//--- include/qtbsr_mem_if.sv
// Port bundle between the readout control and the block status store
interface qtbsr_mem_if;
  logic [qtbsr_pkg::BLK_W-1:0] raddr;
  logic [qtbsr_pkg::ENT_W-1:0] rdata;
  logic                        cmd_we;
  logic [qtbsr_pkg::BLK_W-1:0] cmd_addr;
  logic [1:0]                  cmd_mask;
  logic [1:0]                  cmd_data;
  logic                        op_we;
  logic [qtbsr_pkg::BLK_W-1:0] op_addr;
  logic                        op_data;
  modport ctrl (output raddr, cmd_we, cmd_addr, cmd_mask, cmd_data, op_we, op_addr, op_data, input rdata);
  modport mem  (input raddr, cmd_we, cmd_addr, cmd_mask, cmd_data, op_we, op_addr, op_data, output rdata);
endinterface : qtbsr_mem_if

//--- core/qtbsr_mem.sv
// Block status store, one entry per erase block, registered read
module qtbsr_mem (
  input  wire logic clock_in,
  input  wire logic nrst_in,
  qtbsr_mem_if.mem  mif
);
  import qtbsr_pkg::*;

  logic [ENT_LDOWN:ENT_LOCK] lk [NBLK];
  logic                      er [NBLK];

  // Lock bits clear on reset, so a never locked-down block reads 0 there
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < NBLK; i++) begin
        lk[i] <= M_NONE;
      end
    end else if (mif.cmd_we) begin
      lk[mif.cmd_addr] <= (lk[mif.cmd_addr] & ~mif.cmd_mask) | (mif.cmd_data & mif.cmd_mask);
    end
  end

  // Erase outcome has no reset: it models cells that keep state across power loss
  always_ff @(posedge clock_in) begin
    if (mif.op_we) begin
      er[mif.op_addr] <= mif.op_data;
    end
  end

  // Registered read port
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mif.rdata <= '0;
    end else begin
      mif.rdata <= {er[mif.raddr], lk[mif.raddr]};
    end
  end

  a_erase_mark: assert property (@(posedge clock_in) disable iff (!nrst_in)
    mif.op_we |=> er[$past(mif.op_addr)] == $past(mif.op_data))
    else $error("erase outcome not stored");

  a_erase_keep: assert property (@(posedge clock_in) disable iff (!nrst_in)
    !mif.op_we && er[mif.raddr] |=> er[$past(mif.raddr)])
    else $error("erase outcome cleared without an operation");

  a_erase_hold: assert property (@(posedge clock_in) disable iff (!nrst_in)
    !mif.op_we && !er[mif.raddr] |=> !er[$past(mif.raddr)])
    else $error("erase outcome set without an operation");

endmodule : qtbsr_mem

//--- tb/qtbsr_host.sv
// Host memory controller model issuing word reads and command writes
module qtbsr_host (
  input  wire logic                    clock_in,
  output logic                         ce_n_out,
  output logic                         adv_n_out,
  output logic                         we_n_out,
  output logic                         oe_n_out,
  output logic [qtbsr_pkg::HI_W-1:0]   addr_hi_out,
  output logic [qtbsr_pkg::DQ_W-1:0]   a_dq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import qtbsr_pkg::*;

  // Idle bus at time zero
  initial begin
    ce_n_out    = 1'b1;
    adv_n_out   = 1'b1;
    we_n_out    = 1'b1;
    oe_n_out    = 1'b1;
    addr_hi_out = 7'h00;
    a_dq_out    = 16'h0000;
  end

  // One bus cycle, held up to and past its sampling edge
  task automatic cyc(input logic adv, input logic we, input logic oe, input logic [ADDR_W-1:0] val);
    ce_n_out  = 1'b0;
    adv_n_out = ~adv;
    we_n_out  = ~we;
    oe_n_out  = ~oe;
    {addr_hi_out, a_dq_out} = (adv | we) ? val : ~{addr_hi_out, a_dq_out};
    @(posedge clock_in);
    #1;
  endtask : cyc

  // Bus released for one edge
  task automatic idle();
    ce_n_out  = 1'b1;
    adv_n_out = 1'b1;
    we_n_out  = 1'b1;
    oe_n_out  = 1'b1;
    {addr_hi_out, a_dq_out} = ~{addr_hi_out, a_dq_out}; // Released lines lose the last value
    @(posedge clock_in);
    #1;
  endtask : idle

  // Latch a word address, leave a gap, then one read cycle
  task automatic rd_word(input logic [ADDR_W-1:0] addr);
    cyc(1'b1, 1'b0, 1'b0, addr);
    idle();
    cyc(1'b0, 1'b0, 1'b1, 23'h000000);
    idle();
  endtask : rd_word

  // Mode command to the partition of addr
  task automatic command(input logic [ADDR_W-1:0] addr, input logic [15:0] cmd);
    cyc(1'b1, 1'b0, 1'b0, addr);
    cyc(1'b0, 1'b1, 1'b0, {7'h00, cmd});
    idle();
  endtask : command

  // Lock setup then confirm, confirm two edges after the address
  task automatic lock_op(input logic [ADDR_W-1:0] addr, input logic [15:0] cmd);
    cyc(1'b1, 1'b0, 1'b0, addr);
    cyc(1'b0, 1'b1, 1'b0, {7'h00, CMD_LOCK_SETUP});
    cyc(1'b0, 1'b1, 1'b0, {7'h00, cmd});
    idle();
  endtask : lock_op
endmodule : qtbsr_host

//--- tb/qtbsr_top_bench.sv
// Self-checking bench for the query table and block status readout
module qtbsr_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import qtbsr_pkg::*;

  logic              clock_in = 1'b0;
  logic              nrst_in  = 1'b0;
  logic              ce_n, adv_n, we_n, oe_n;
  logic [HI_W-1:0]   addr_hi;
  logic [DQ_W-1:0]   host_dq, dq_out, array_data;
  logic              dq_oe;
  logic [7:0]        status_byte;
  logic              op_start, op_erase, erase_done, erase_ok;
  logic [BLK_W-1:0]  op_block, erase_block;
  logic [15:0]       seed = 16'h003f;
  logic [15:0]       exp_q[$];
  int                n_errors = 0;
  int                samples_checked = 0;
  int                cycles = 0;
  wire  [DQ_W-1:0]   bus_dq = dq_oe ? dq_out : host_dq;

  // Host side and device
  qtbsr_host host (.clock_in(clock_in), .ce_n_out(ce_n), .adv_n_out(adv_n), .we_n_out(we_n),
                   .oe_n_out(oe_n), .addr_hi_out(addr_hi), .a_dq_out(host_dq));
  qtbsr_top uut (.clock_in(clock_in), .nrst_in(nrst_in), .ce_n_in(ce_n), .adv_n_in(adv_n), .we_n_in(we_n),
                 .oe_n_in(oe_n), .addr_hi_in(addr_hi), .a_dq_in(bus_dq), .a_dq_out(dq_out),
                 .a_dq_oe_out(dq_oe), .array_data_in(array_data), .status_byte_in(status_byte),
                 .op_start_in(op_start), .op_erase_in(op_erase), .op_block_in(op_block),
                 .erase_done_in(erase_done), .erase_ok_in(erase_ok), .erase_block_in(erase_block));

  // Clock
  always #10 clock_in = ~clock_in;

  // Pseudo-random source
  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction : rnd

  // Reference query contents
  function automatic logic [7:0] q_ref(input logic [7:0] off);
    case (off)
      8'h10: return 8'h51;
      8'h11: return 8'h52;
      8'h12: return 8'h59;
      8'h13: return PRIMARY_CMDSET_IDENTIFIER[7:0];
      8'h14: return PRIMARY_CMDSET_IDENTIFIER[15:8];
      8'h15: return PRIMARY_EXT_TABLE_ADDR[7:0];
      8'h16: return PRIMARY_EXT_TABLE_ADDR[15:8];
      default: return 8'h00;
    endcase
  endfunction : q_ref

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Note the expected word, then read it
  task automatic rd_exp(input logic [ADDR_W-1:0] addr, input logic [15:0] exp);
    exp_q.push_back(exp);
    host.rd_word(addr);
  endtask : rd_exp

  // Operation start or erase completion pulse
  task automatic ev(input logic start, input logic flag, input logic [BLK_W-1:0] blk);
    op_start    = start;
    op_erase    = flag;
    op_block    = blk;
    erase_done  = ~start;
    erase_ok    = flag;
    erase_block = blk;
    @(posedge clock_in);
    #1;
    op_start   = 1'b0;
    erase_done = 1'b0;
    @(posedge clock_in);
    #1;
  endtask : ev

  // Compare every driven word with the oldest note
  always @(negedge clock_in) begin
    if (dq_oe === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_errors++;
        $display("BAD read word expected none seen %h", dq_out);
      end else begin
        chk("read word", exp_q.pop_front(), dq_out);
      end
    end
  end

  // Hang guard
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 8000) begin
      n_errors++;
      $display("BAD timeout expected end seen %0d cycles", cycles);
      close_out();
    end
  end

  // Main sequence
  initial begin
    logic [7:0]        off;
    logic [BLK_W-1:0]  blk;
    logic [ADDR_W-1:0] ba;
    logic [7:0]        er;
    array_data  = rnd();
    status_byte = 8'h00;
    op_start    = 1'b0;
    op_erase    = 1'b0;
    op_block    = 6'h00;
    erase_done  = 1'b0;
    erase_ok    = 1'b0;
    erase_block = 6'h00;
    er          = 8'h01 << STAT_ERASE;
    repeat (4) @(posedge clock_in);
    #1;
    nrst_in = 1'b1;
    // Query mode on partition 1, boundaries then random offsets
    host.command(23'h100000, CMD_QUERY);
    for (int i = 0; i < 40; i++) begin
      off = (i < 16) ? 8'h0c + i[7:0] : 8'(rnd());
      rd_exp({3'h1, 12'h000, off}, {8'h00, q_ref(off)});
    end
    // Other partition stays in array mode, then partition 1 returns to it
    for (int p = 0; p < 2; p++) begin
      array_data = rnd();
      rd_exp({p[2:0], 20'h00010}, array_data);
      host.command(23'h100000, CMD_READ_ARRAY);
    end
    // Status mode shows the status byte on the low lines
    status_byte = 8'(rnd());
    host.command(23'h300000, CMD_READ_STATUS);
    rd_exp(23'h300000, {8'h00, status_byte});
    // Block status on edge and random blocks
    for (int b = 0; b < 4; b++) begin
      blk = (b == 0) ? 6'h00 : (b == 1) ? 6'h01 : (b == 2) ? 6'h3f : 6'h02 + 6'(rnd() % 16'd61);
      ba  = {blk, 17'h00000};
      host.command(ba, CMD_READ_INFO);
      host.lock_op(ba, CMD_LOCK);
      ev(1'b1, 1'b0, blk);
      rd_exp(ba, 16'h0000);
      rd_exp(ba + 23'h3, 16'h0000);
      rd_exp(ba + 23'h2, 16'h0001);
      host.lock_op(ba, CMD_UNLOCK);
      rd_exp(ba + 23'h2, 16'h0000);
      ev(1'b1, 1'b1, blk);
      rd_exp(ba + 23'h2, {8'h00, er});
      ev(1'b0, 1'b0, blk);
      rd_exp(ba + 23'h2, {8'h00, er});
      ev(1'b0, 1'b1, blk);
      rd_exp(ba + 23'h2, 16'h0000);
      ev(1'b1, 1'b1, blk);
      ev(1'b1, 1'b0, blk);
      rd_exp(ba + 23'h2, 16'h0000);
      host.lock_op(ba, CMD_LOCKDOWN);
      host.lock_op(ba, CMD_UNLOCK);
      rd_exp(ba + 23'h2, 16'h0003);
    end
    // Reset mid-run: lock bits clear, the erase outcome survives
    ba = 23'h020000;
    ev(1'b1, 1'b1, 6'h01);
    nrst_in = 1'b0;
    repeat (2) @(posedge clock_in);
    #1;
    nrst_in = 1'b1;
    host.command(ba, CMD_READ_INFO);
    rd_exp(ba + 23'h2, {8'h00, er});
    repeat (3) @(posedge clock_in);
    if (exp_q.size() != 0) begin
      n_errors++;
      $display("BAD pending reads expected 0 seen %0d", exp_q.size());
    end
    close_out();
  end
endmodule : qtbsr_top_bench
